// File: design/scm_clkdiv.sv
// collision detect clock divider, one-cycle tick at the chosen rate
`timescale 1ns/1ps
module scm_clkdiv (
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset_n,
    // division select and tick
    input  scm_pkg::scm_div_e      i_div,
    output logic                   o_tick
);
    logic [1:0] cnt_r;
    logic       tick_r;

    // free running count, base clock ticks every cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cnt_r  <= 2'h0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            case (i_div)
                scm_pkg::SCM_DIV_1: tick_r <= 1'b1;
                scm_pkg::SCM_DIV_2: tick_r <= cnt_r[0];
                scm_pkg::SCM_DIV_4: tick_r <= &cnt_r;
                default:            tick_r <= 1'b0;
            endcase
        end
    end

    assign o_tick = tick_r;
endmodule

// File: design/scm_consts.svh
// register offsets, field positions and reset values of the serial mode block
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH

// ****************************************
// byte offsets on the register bus
// ****************************************
`define SCM_OFF_MODE   8'h00
`define SCM_OFF_CTRL   8'h04
`define SCM_OFF_CARD   8'h08
`define SCM_OFF_EXT    8'h0C
`define SCM_OFF_TWI    8'h10
`define SCM_OFF_SPI    8'h14
`define SCM_OFF_CTRL2  8'h18
`define SCM_OFF_STAT   8'h1C
`define SCM_OFF_MASK   8'h20
`define SCM_OFF_RXDAT  8'h24
`define SCM_OFF_INFO   8'h28

// ****************************************
// field positions
// ****************************************
`define SCM_MODE_PRESC 0
`define SCM_MODE_MP    2
`define SCM_MODE_CHRL  6
`define SCM_MODE_CM    7
`define SCM_CTRL_CKE   0
`define SCM_CTRL_MULTIPROC_WAIT_ENABLE  3
`define SCM_CARD_SMARTCARD_SELECT  0
`define SCM_CARD_CHRH  4
`define SCM_EXT_ACS    0
`define SCM_EXT_BASE_CLOCK_HALVE_SELECT   4
`define SCM_EXT_BAUD_DOUBLE_SPEED   6
`define SCM_TWI_SIMPLE_TWOWIRE_SELECT   0
`define SCM_SPI_EN     0
`define SCM_SPI_MSS    2
`define SCM_CTRL2_BCCS 4
`define SCM_ST_FULL    0
`define SCM_ST_OVR     1
`define SCM_ST_FRM     2
`define SCM_ST_PAR     3
`define SCM_ST_WAKE    4

// ****************************************
// reset values
// ****************************************
`define SCM_RST_REG    8'h00
`define SCM_RST_CARD   8'h10
`define SCM_RST_STAT   5'h00

`endif

// File: design/scm_pkg.sv
// types shared by the serial mode block
package scm_pkg;
    // operating family chosen by the card and two-wire selects
    typedef enum logic [1:0] {
        SCM_MODE_SERIAL = 2'b00,
        SCM_MODE_TWI    = 2'b01,
        SCM_MODE_CARD   = 2'b10,
        SCM_MODE_BAD    = 2'b11
    } scm_mode_e;
    // collision clock division
    typedef enum logic [1:0] {
        SCM_DIV_1    = 2'b00,
        SCM_DIV_2    = 2'b01,
        SCM_DIV_4    = 2'b10,
        SCM_DIV_NONE = 2'b11
    } scm_div_e;
endpackage

// File: design/scm_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module scm_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_reset_n,
    // pins and result
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // meta_r feeds sync_r only
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule

// File: design/scm_top.sv
// serial mode, frame length and clock source configuration block
// Function
// RQ1: async length bits give nine, eight, seven
// RQ2: mode bit picks async or synchronous
// RQ3: async source 00 keeps clock pin hi-z
// RQ4: async source 01 drives bit clock out
// RQ5: partner gives sixteen or eight times clock
// RQ6: timer clock source keeps clock pin hi-z
// RQ7: sync mode: 0x drives, 1x inputs clock
// RQ8: wait mode drops frames with zero flag
// RQ9: flagged frame clears wait bit, resumes reception
// RQ10: source select: pin, or timer matches AND
// RQ11: timer clock only on channels 5,6,12
// RQ12: card/two-wire selects decode four operating families
// RQ13: spi master/slave swaps data pin roles
// RQ14: collision clock: base, half, quarter
// RQ15: double speed, prescale 00: half, quarter
// RQ16: all logic on peripheral clock b
// RQ17: parity, overrun, framing errors each flagged
// RQ18: prohibited encodings give no defined behaviour
`timescale 1ns/1ps
`include "scm_consts.svh"
module scm_top #(
    parameter int CHANNEL = 5
) (
    // clock and reset, the system clock is peripheral clock b
    input  wire logic        i_sys_clk, // RQ16
    input  wire logic        i_reset_n,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // receiver frame strobe
    input  wire logic        i_rx_valid,
    input  wire logic [8:0]  i_rx_data,
    input  wire logic        i_rx_mp_bit,
    input  wire logic        i_rx_par_err,
    input  wire logic        i_rx_frm_err,
    // clock sources
    input  wire logic        i_bit_clk,
    input  wire logic        i_timer_match_a,
    input  wire logic        i_timer_match_b,
    // serial clock pin
    input  wire logic        i_sck_in,
    output logic             o_sck_out,
    output logic             o_sck_oe,
    // spi data pins
    input  wire logic        i_spi_out_in,
    output logic             o_spi_out_out,
    output logic             o_spi_out_oe,
    input  wire logic        i_spi_in_in,
    output logic             o_spi_in_out,
    output logic             o_spi_in_oe,
    input  wire logic        i_tx_bit,
    output logic             o_rx_bit,
    // derived configuration
    output logic             o_clk_sel,
    output logic             o_ratio_8x,
    output logic [3:0]       o_char_bits,
    output logic [1:0]       o_mode,
    output logic             o_collision_tick,
    output logic             o_irq
);
    // ****************************************
    // decode helpers
    // ****************************************

    // timer clock wiring exists on three channels only
    localparam logic TIMER_OK = (CHANNEL == 5) || (CHANNEL == 6) || (CHANNEL == 12); // RQ11

    // data bits per character
    function automatic logic [3:0] char_bits(input logic cm, input logic hi, input logic lo);
        if (cm) begin
            char_bits = 4'h8;
        end else if (!hi) begin
            char_bits = 4'h9; // RQ1
        end else if (lo) begin
            char_bits = 4'h7; // RQ1
        end else begin
            char_bits = 4'h8; // RQ1
        end
    endfunction

    // collision clock divisor; prohibited codes stop the tick
    function automatic scm_pkg::scm_div_e coll_div(input logic dbl, input logic [1:0] presc,
                                                   input logic [1:0] sel);
        if (dbl && presc == 2'h0) begin
            case (sel)
                2'h0:    coll_div = scm_pkg::SCM_DIV_2; // RQ15
                2'h1:    coll_div = scm_pkg::SCM_DIV_4; // RQ15
                default: coll_div = scm_pkg::SCM_DIV_NONE; // RQ18
            endcase
        end else begin
            case (sel)
                2'h0:    coll_div = scm_pkg::SCM_DIV_1; // RQ14
                2'h1:    coll_div = scm_pkg::SCM_DIV_2; // RQ14
                2'h2:    coll_div = scm_pkg::SCM_DIV_4; // RQ14
                default: coll_div = scm_pkg::SCM_DIV_NONE; // RQ18
            endcase
        end
    endfunction

    // ****************************************
    // registers and wires
    // ****************************************
    logic [7:0] mode_r;
    logic [7:0] ctrl_r;
    logic [7:0] card_r;
    logic [7:0] ext_r;
    logic [7:0] twi_r;
    logic [7:0] spi_r;
    logic [7:0] ctrl2_r;
    logic [4:0] stat_r;
    logic [4:0] mask_r;
    logic [8:0] rx_data_r;
    logic       full_r;
    logic       ack_r;
    logic [31:0] dat_r;
    logic [31:0] rd_val;
    logic       irq_r;
    logic       sck_out_r;
    logic       sck_oe_r;
    logic       clk_sel_r;
    logic       ratio_r;
    logic [3:0] char_r;
    logic [1:0] mode_out_r;
    logic       so_out_r;
    logic       so_oe_r;
    logic       si_out_r;
    logic       si_oe_r;
    logic       rx_bit_r;
    logic [2:0] pins_s;
    logic       req;
    logic       wr;
    logic       rd_stat;
    logic       rd_data;
    logic       async_m;
    logic       mp_filter;
    logic       discard;
    logic       wake;
    logic       accept;
    logic       ovr_ev;
    logic       spi_act;
    logic       master;
    scm_pkg::scm_div_e div_sel;

    // pin inputs pass two flops before any use
    scm_sync #(
        .W (3)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_async   ({i_sck_in, i_spi_out_in, i_spi_in_in}),
        .o_sync    (pins_s)
    );

    // ****************************************
    // wishbone slave
    // ****************************************

    // one-cycle registered answer; ack drops after one cycle
    assign req     = i_wb_cyc && i_wb_stb && !ack_r;
    assign wr      = req && i_wb_we && i_wb_sel[0];
    assign rd_stat = req && !i_wb_we && i_wb_adr == `SCM_OFF_STAT;
    assign rd_data = req && !i_wb_we && i_wb_adr == `SCM_OFF_RXDAT;

    // read mux, narrow registers from bit 0 up, unmapped reads zero
    always_comb begin
        rd_val = 32'h0;
        case (i_wb_adr)
            `SCM_OFF_MODE:  rd_val[7:0] = mode_r;
            `SCM_OFF_CTRL:  rd_val[7:0] = ctrl_r;
            `SCM_OFF_CARD:  rd_val[7:0] = card_r;
            `SCM_OFF_EXT:   rd_val[7:0] = ext_r;
            `SCM_OFF_TWI:   rd_val[7:0] = twi_r;
            `SCM_OFF_SPI:   rd_val[7:0] = spi_r;
            `SCM_OFF_CTRL2: rd_val[7:0] = ctrl2_r;
            `SCM_OFF_STAT:  rd_val[4:0] = stat_r;
            `SCM_OFF_MASK:  rd_val[4:0] = mask_r;
            `SCM_OFF_RXDAT: rd_val[8:0] = rx_data_r;
            `SCM_OFF_INFO:  rd_val[7:0] = {full_r, sck_oe_r, mode_out_r, char_r};
            default:        rd_val = 32'h0;
        endcase
    end

    // answer handshake
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= req;
            dat_r <= req ? rd_val : 32'h0;
        end
    end

    // plain configuration registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            mode_r  <= `SCM_RST_REG;
            card_r  <= `SCM_RST_CARD;
            ext_r   <= `SCM_RST_REG;
            twi_r   <= `SCM_RST_REG;
            spi_r   <= `SCM_RST_REG;
            ctrl2_r <= `SCM_RST_REG;
            mask_r  <= `SCM_RST_STAT;
        end else if (wr) begin
            case (i_wb_adr)
                `SCM_OFF_MODE:  mode_r  <= i_wb_dat[7:0];
                `SCM_OFF_CARD:  card_r  <= i_wb_dat[7:0];
                `SCM_OFF_EXT:   ext_r   <= i_wb_dat[7:0] & {7'h7F, TIMER_OK}; // RQ11
                `SCM_OFF_TWI:   twi_r   <= i_wb_dat[7:0];
                `SCM_OFF_SPI:   spi_r   <= i_wb_dat[7:0];
                `SCM_OFF_CTRL2: ctrl2_r <= i_wb_dat[7:0];
                `SCM_OFF_MASK:  mask_r  <= i_wb_dat[4:0];
                default:        mask_r  <= mask_r;
            endcase
        end
    end

    // control register; a waking frame beats a same-cycle write so it is never missed
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            ctrl_r <= `SCM_RST_REG;
        end else if (wake) begin
            ctrl_r[`SCM_CTRL_MULTIPROC_WAIT_ENABLE] <= 1'b0; // RQ9
        end else if (wr && i_wb_adr == `SCM_OFF_CTRL) begin
            ctrl_r <= i_wb_dat[7:0];
        end
    end

    // ****************************************
    // receive filtering and status
    // ****************************************

    // zero-flag frames vanish while waiting for an address frame
    assign async_m   = !mode_r[`SCM_MODE_CM]; // RQ2
    assign mp_filter = async_m && mode_r[`SCM_MODE_MP] && ctrl_r[`SCM_CTRL_MULTIPROC_WAIT_ENABLE];
    assign discard   = mp_filter && !i_rx_mp_bit; // RQ8
    assign wake      = i_rx_valid && mp_filter && i_rx_mp_bit; // RQ9
    assign accept    = i_rx_valid && !discard; // RQ8
    assign ovr_ev    = accept && full_r && !rd_data; // RQ17

    // receive data; an overrun keeps the unread character
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            rx_data_r <= 9'h000;
        end else if (accept && !ovr_ev) begin
            case (char_bits(mode_r[`SCM_MODE_CM], card_r[`SCM_CARD_CHRH],
                            mode_r[`SCM_MODE_CHRL]))
                4'h9:    rx_data_r <= i_rx_data; // RQ1
                4'h7:    rx_data_r <= {2'h0, i_rx_data[6:0]}; // RQ1
                default: rx_data_r <= {1'b0, i_rx_data[7:0]}; // RQ1
            endcase
        end
    end

    // buffer full: a new frame wins over a data read in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            full_r <= 1'b0;
        end else if (accept) begin
            full_r <= 1'b1; // RQ8
        end else if (rd_data) begin
            full_r <= 1'b0;
        end
    end

    // sticky events cleared by a status read; a set in that cycle survives
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            stat_r <= `SCM_RST_STAT;
        end else begin
            stat_r[`SCM_ST_FULL] <= accept || (stat_r[`SCM_ST_FULL] && !rd_stat);
            stat_r[`SCM_ST_OVR]  <= ovr_ev || (stat_r[`SCM_ST_OVR] && !rd_stat); // RQ17
            stat_r[`SCM_ST_FRM]  <= (accept && async_m && i_rx_frm_err)
                                    || (stat_r[`SCM_ST_FRM] && !rd_stat); // RQ17
            stat_r[`SCM_ST_PAR]  <= (accept && async_m && i_rx_par_err)
                                    || (stat_r[`SCM_ST_PAR] && !rd_stat); // RQ17
            stat_r[`SCM_ST_WAKE] <= wake || (stat_r[`SCM_ST_WAKE] && !rd_stat);
        end
    end

    // level interrupt from unmasked events
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & mask_r);
        end
    end

    // ****************************************
    // clock pin and clock source
    // ****************************************

    // pin direction follows mode and source field
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            sck_oe_r  <= 1'b0;
            sck_out_r <= 1'b0;
        end else if (!async_m) begin
            sck_oe_r  <= !ctrl_r[`SCM_CTRL_CKE+1]; // RQ7
            sck_out_r <= !ctrl_r[`SCM_CTRL_CKE+1] && i_bit_clk; // RQ7
        end else begin
            // 00, 1x external and timer all leave the pin floating
            sck_oe_r  <= ctrl_r[`SCM_CTRL_CKE+:2] == 2'h1; // RQ3 RQ4 RQ6
            sck_out_r <= ctrl_r[`SCM_CTRL_CKE+:2] == 2'h1 && i_bit_clk; // RQ4
        end
    end

    // selected bit clock; timer matches are on-chip and need no sync
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            clk_sel_r <= 1'b0;
            ratio_r   <= 1'b0;
        end else begin
            if (!ctrl_r[`SCM_CTRL_CKE+1]) begin
                clk_sel_r <= i_bit_clk;
            end else if (async_m && ext_r[`SCM_EXT_ACS] && TIMER_OK) begin
                clk_sel_r <= i_timer_match_a && i_timer_match_b; // RQ10
            end else begin
                clk_sel_r <= pins_s[2]; // RQ10
            end
            // external rate expected from the partner: 8x or 16x
            ratio_r <= ext_r[`SCM_EXT_BASE_CLOCK_HALVE_SELECT]; // RQ5
        end
    end

    // ****************************************
    // mode decode and spi pins
    // ****************************************

    assign spi_act = !async_m && spi_r[`SCM_SPI_EN]
                     && mode_out_r == scm_pkg::SCM_MODE_SERIAL;
    assign master  = !spi_r[`SCM_SPI_MSS];

    // registered decode of family and character length
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            mode_out_r <= scm_pkg::SCM_MODE_SERIAL;
            char_r     <= 4'h8;
        end else begin
            mode_out_r <= {card_r[`SCM_CARD_SMARTCARD_SELECT], twi_r[`SCM_TWI_SIMPLE_TWOWIRE_SELECT]}; // RQ12
            char_r     <= char_bits(mode_r[`SCM_MODE_CM], card_r[`SCM_CARD_CHRH],
                                    mode_r[`SCM_MODE_CHRL]); // RQ1
        end
    end

    // master sends on the out pin, slave on the in pin
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            so_oe_r  <= 1'b0;
            so_out_r <= 1'b0;
            si_oe_r  <= 1'b0;
            si_out_r <= 1'b0;
            rx_bit_r <= 1'b0;
        end else begin
            so_oe_r  <= spi_act && master; // RQ13
            so_out_r <= spi_act && master && i_tx_bit; // RQ13
            si_oe_r  <= spi_act && !master; // RQ13
            si_out_r <= spi_act && !master && i_tx_bit; // RQ13
            rx_bit_r <= (spi_act && !master) ? pins_s[1] : pins_s[0]; // RQ13
        end
    end

    // collision detect clock
    assign div_sel = coll_div(ext_r[`SCM_EXT_BAUD_DOUBLE_SPEED], mode_r[`SCM_MODE_PRESC+:2],
                              ctrl2_r[`SCM_CTRL2_BCCS+:2]);

    scm_clkdiv u_div (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_div     (div_sel),
        .o_tick    (o_collision_tick)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign o_wb_dat      = dat_r;
    assign o_wb_ack      = ack_r;
    assign o_irq         = irq_r;
    assign o_sck_out     = sck_out_r;
    assign o_sck_oe      = sck_oe_r;
    assign o_clk_sel     = clk_sel_r;
    assign o_ratio_8x    = ratio_r;
    assign o_char_bits   = char_r;
    assign o_mode        = mode_out_r;
    assign o_spi_out_out = so_out_r;
    assign o_spi_out_oe  = so_oe_r;
    assign o_spi_in_out  = si_out_r;
    assign o_spi_in_oe   = si_oe_r;
    assign o_rx_bit      = rx_bit_r;

    // ****************************************
    // assertions
    // ****************************************
    property p_char_len;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (async_m && !card_r[`SCM_CARD_CHRH]) |=> (o_char_bits == 4'h9);
    endproperty
    a_char_len: assert property (p_char_len) else $error("nine-bit length lost"); // RQ1

    property p_sck_hiz;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (async_m && ctrl_r[1:0] != 2'h1) |=> !o_sck_oe;
    endproperty
    a_sck_hiz: assert property (p_sck_hiz) else $error("clock pin driven"); // RQ3

    property p_sck_drive;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (async_m && ctrl_r[1:0] == 2'h1) |=> (o_sck_oe && o_sck_out == $past(i_bit_clk));
    endproperty
    a_sck_drive: assert property (p_sck_drive) else $error("bit clock not out"); // RQ4

    property p_sync_sck;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        !async_m |=> (o_sck_oe == !$past(ctrl_r[1]));
    endproperty
    a_sync_sck: assert property (p_sync_sck) else $error("sync clock dir wrong"); // RQ7

    property p_discard;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_rx_valid && discard && !full_r) |=> (!full_r && !$rose(stat_r[`SCM_ST_FRM]));
    endproperty
    a_discard: assert property (p_discard) else $error("discarded frame seen"); // RQ8

    property p_wake;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        wake |=> (!ctrl_r[`SCM_CTRL_MULTIPROC_WAIT_ENABLE] && full_r);
    endproperty
    a_wake: assert property (p_wake) else $error("wait bit not cleared"); // RQ9

    property p_coll_dbl;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (div_sel == scm_pkg::SCM_DIV_2)[*3] |-> (o_collision_tick != $past(o_collision_tick));
    endproperty
    a_coll_dbl: assert property (p_coll_dbl) else $error("half rate tick wrong"); // RQ15

    property p_overrun;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        ovr_ev |=> (stat_r[`SCM_ST_OVR] && $stable(rx_data_r));
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // RQ17

    property p_spi_master;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (spi_act && master) |=> (o_spi_out_oe && !o_spi_in_oe);
    endproperty
    a_spi_master: assert property (p_spi_master) else $error("spi pin roles wrong"); // RQ13

    property p_mode_twi;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (!card_r[0] && twi_r[0]) |=> (o_mode == scm_pkg::SCM_MODE_TWI);
    endproperty
    a_mode_twi: assert property (p_mode_twi) else $error("two-wire decode wrong"); // RQ12
endmodule

// File: tb/scm_partner.sv
// far-side serial device: external clock source and data line
`timescale 1ns/1ps
module scm_partner (
    // control from the bench
    input  wire logic i_clk,
    input  wire logic i_run,
    input  wire logic i_ratio_8x,
    // lines toward the device
    output logic      o_sck,
    output logic      o_dat
);
    logic [3:0] cnt_r;
    logic       tog_r = 1'b0;
    // clock stands high outside transfers, half period 8 or 4 cycles
    always_ff @(posedge i_clk) begin
        if (!i_run) begin
            cnt_r <= 4'h0;
            o_sck <= 1'b1;
        end else if (cnt_r == (i_ratio_8x ? 4'h3 : 4'h7)) begin
            cnt_r <= 4'h0;
            o_sck <= ~o_sck;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    // data flips every cycle so a released line never looks stable
    always_ff @(posedge i_clk) begin
        tog_r <= ~tog_r;
    end
    assign o_dat = tog_r;
endmodule

// File: tb/scm_top_tb.sv
// self-checking bench of the serial mode block
`timescale 1ns/1ps
`include "scm_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module scm_top_tb;
    logic i_sys_clk = 1'b0, i_reset_n = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic i_rx_valid = 1'b0, i_rx_mp_bit = 1'b0, i_rx_par_err = 1'b0, i_rx_frm_err = 1'b0;
    logic i_bit_clk = 1'b1, i_timer_match_a = 1'b0, i_timer_match_b = 1'b0, i_tx_bit = 1'b1;
    logic [7:0]  i_wb_adr = 8'h00;
    logic [3:0]  i_wb_sel = 4'hF;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rv;
    logic [8:0]  i_rx_data = 9'h0A5;
    logic o_wb_ack, o_sck_out, o_sck_oe, o_spi_out_out, o_spi_out_oe, o_spi_in_out, o_spi_in_oe;
    logic o_rx_bit, o_clk_sel, o_ratio_8x, o_collision_tick, o_irq, p_sck, p_dat, run = 1'b0;
    logic [3:0]  o_char_bits;
    logic [1:0]  o_mode;
    // pin levels resolved from the device's enables, partner drives otherwise
    wire i_sck_in = o_sck_oe ? o_sck_out : p_sck;
    wire i_spi_out_in = o_spi_out_oe ? o_spi_out_out : p_dat;
    wire i_spi_in_in = o_spi_in_oe ? o_spi_in_out : ~p_dat;
    int mismatches = 0, checked = 0, i, j, n;
    int exp_ticks [2][4] = '{'{16, 8, 4, 0}, '{8, 4, 0, 0}};
    // 50 MHz system clock
    always #10 i_sys_clk = ~i_sys_clk;
    scm_partner u_far (.i_clk(i_sys_clk), .i_run(run), .i_ratio_8x(o_ratio_8x),
                       .o_sck(p_sck), .o_dat(p_dat));
    scm_top #(.CHANNEL(5)) uut (.*);
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one classic wishbone cycle; ack is sampled at the rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge i_sys_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= w;
        i_wb_adr <= a;
        i_wb_dat <= {24'h0, d};
        k = 0;
        do begin
            @(posedge i_sys_clk);
            k++;
        end while (o_wb_ack !== 1'b1 && k < 20);
        if (k >= 20) begin
            mismatches++;
            print_verdict();
        end
        rv = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we  <= 1'b0;
        @(negedge i_sys_clk);
    endtask
    // one received frame strobe
    task automatic frame(input logic m, input logic p, input logic f);
        @(posedge i_sys_clk);
        i_rx_valid   <= 1'b1;
        i_rx_mp_bit  <= m;
        i_rx_par_err <= p;
        i_rx_frm_err <= f;
        @(posedge i_sys_clk);
        i_rx_valid <= 1'b0;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        bus(0, `SCM_OFF_CARD, 8'h00);
        `CHK(rv, 32'h10)
        bus(1, 8'h3C, 8'hFF);
        bus(0, 8'h3C, 8'h00);
        `CHK(rv, 32'h0)
        i_wb_sel = 4'h0;
        bus(1, `SCM_OFF_MODE, 8'h80);
        i_wb_sel = 4'hF;
        bus(0, `SCM_OFF_MODE, 8'h00);
        `CHK(rv, 32'h0)
        $display("test registers done");
        for (i = 0; i < 4; i++) begin
            bus(1, `SCM_OFF_CARD, {3'h0, i[1], 4'h0});
            bus(1, `SCM_OFF_MODE, {1'b0, i[0], 6'h0});
            `CHK(o_char_bits, (i == 3) ? 4'h7 : (i == 2) ? 4'h8 : 4'h9)
        end
        $display("test length done");
        bus(1, `SCM_OFF_CARD, 8'h00);
        for (j = 0; j < 8; j++) begin
            bus(1, `SCM_OFF_MODE, {j[2], 7'h0});
            bus(1, `SCM_OFF_CTRL, {6'h0, j[1:0]});
            `CHK({o_sck_oe, o_sck_out}, {2{j[2] ? !j[1] : (j[1:0] == 2'b01)}})
            `CHK(o_char_bits, j[2] ? 4'h8 : 4'h9)
        end
        $display("test clock pin done");
        bus(1, `SCM_OFF_MODE, 8'h00);
        bus(1, `SCM_OFF_CTRL, 8'h02);
        bus(1, `SCM_OFF_EXT, 8'h10);
        `CHK(o_ratio_8x, 1'b1)
        run = 1'b1;
        n = 0;
        rv = 32'h7;
        repeat (40) begin
            @(negedge i_sys_clk);
            if (o_clk_sel !== rv[2]) n++;
            rv = {rv[30:0], i_sck_in};
        end
        run = 1'b0;
        `CHK(n, 0)
        bus(1, `SCM_OFF_EXT, 8'h01);
        for (j = 0; j < 2; j++) begin
            @(posedge i_sys_clk);
            i_timer_match_a <= 1'b1;
            i_timer_match_b <= !j[0];
            repeat (3) @(negedge i_sys_clk);
            `CHK(o_clk_sel, !j[0])
            `CHK(o_sck_oe, 1'b0)
        end
        $display("test clock source done");
        for (j = 0; j < 4; j++) begin
            bus(1, `SCM_OFF_CARD, {7'h08, j[1]});
            bus(1, `SCM_OFF_TWI, {7'h0, j[0]});
            `CHK(o_mode, j[1:0])
        end
        bus(1, `SCM_OFF_CARD, 8'h10);
        bus(1, `SCM_OFF_TWI, 8'h00);
        bus(1, `SCM_OFF_MODE, 8'h80);
        for (j = 0; j < 2; j++) begin
            bus(1, `SCM_OFF_SPI, {5'h0, j[0], 2'b01});
            `CHK({o_spi_out_oe,o_spi_in_oe,o_spi_out_out,o_spi_in_out}, {2{!j[0],j[0]}})
            repeat (3) @(negedge i_sys_clk);
            `CHK(o_rx_bit, p_dat ^ j[0])
        end
        $display("test modes done");
        bus(1, `SCM_OFF_MODE, 8'h00);
        for (i = 0; i < 2; i++) begin
            bus(1, `SCM_OFF_EXT, {1'b0, i[0], 6'h0});
            for (j = 0; j < 4; j++) begin
                bus(1, `SCM_OFF_CTRL2, {2'h0, j[1:0], 4'h0});
                n = 0;
                repeat (16) begin
                    @(negedge i_sys_clk);
                    if (o_collision_tick === 1'b1) n++;
                end
                `CHK(n, exp_ticks[i][j])
            end
        end
        $display("test collision clock done");
        bus(1, `SCM_OFF_MODE, 8'h04);
        bus(1, `SCM_OFF_CTRL, 8'h08);
        bus(1, `SCM_OFF_MASK, 8'h1F);
        frame(0, 1, 1);
        bus(0, `SCM_OFF_STAT, 8'h00);
        `CHK(rv, 32'h0)
        frame(1, 0, 0);
        bus(0, `SCM_OFF_CTRL, 8'h00);
        `CHK(rv, 32'h0)
        `CHK(o_irq, 1'b1)
        bus(0, `SCM_OFF_STAT, 8'h00);
        `CHK(rv, 32'h11)
        `CHK(o_irq, 1'b0)
        frame(1, 1, 1);
        frame(1, 0, 0);
        bus(0, `SCM_OFF_STAT, 8'h00);
        `CHK(rv, 32'h0F)
        bus(1, `SCM_OFF_MASK, 8'h00);
        frame(1, 0, 0);
        repeat (2) @(negedge i_sys_clk);
        `CHK(o_irq, 1'b0)
        bus(1, `SCM_OFF_MASK, 8'h01);
        `CHK(o_irq, 1'b1)
        $display("test receive done");
        print_verdict();
    end
endmodule
